// >>> cpu_regs_pkg.sv
// constants and types for the core control and general register block
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package cpu_regs_pkg;
	// register offsets on the bus
	localparam logic [7:0] OFS_FETCH = 8'h00;
	localparam logic [7:0] OFS_FLAG = 8'h04;
	localparam logic [7:0] OFS_STACK = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_GPR_BASE = 8'h80;
	// flag word bit positions
	localparam int FLG_GATE = 7;
	localparam int FLG_NULL = 6;
	localparam int FLG_BANKH = 5;
	localparam int FLG_HALF = 4;
	localparam int FLG_BANKL = 3;
	localparam int FLG_LEVEL = 1;
	localparam int FLG_CARRY = 0;
	localparam logic [7:0] FLAG_RESET = 8'h02;
	localparam logic [7:0] FLAG_USED = 8'hfb;
	// address map
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] STACK_LO = 16'hfb00;
	localparam logic [15:0] STACK_HI = 16'hfeff;
	localparam logic [15:0] GPR_BASE = 16'hfee0;
	// stack byte counts per sequence
	localparam logic [1:0] LEN_ENTRY = 2'h3;
	localparam logic [1:0] LEN_CALL = 2'h2;
	localparam logic [1:0] LEN_FLAG = 2'h1;
	// commands from the decoder
	typedef enum logic [3:0] {
		OP_SEQ, OP_BRANCH, OP_CALL, OP_RET, OP_ENTRY, OP_IRQ_RETURN_OP, OP_PUSHF, OP_POPF,
		OP_MASK, OP_UNMASK, OP_BANK, OP_ALU, OP_CARRY, OP_LDSP, OP_NOP1, OP_NOP2
	} op_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_PUSH, ST_POP_RD, ST_POP_WT, ST_VEC_RD, ST_VEC_WT
	} state_t;
endpackage : cpu_regs_pkg

// >>> cpu_regs.sv
// control registers, flag word, stack sequencer and banked general registers
`timescale 1ns/1ps
module cpu_regs (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmdValid,
	input wire cpu_regs_pkg::op_t cmdOp,
	input wire logic [2:0] cmdLen,
	input wire logic [15:0] cmdTarget,
	input wire logic cmdFromPair,
	input wire logic [1:0] cmdPair,
	input wire logic [1:0] cmdBank,
	input wire logic [15:0] cmdVector,
	input wire logic [7:0] aluA,
	input wire logic [7:0] aluB,
	input wire logic aluSub,
	input wire logic aluUseCarry,
	input wire logic cmdBit,
	input wire logic irqReq,
	input wire logic irqLowPrio,
	input wire logic irqMasked,
	input wire logic [2:0] gprRdIdx,
	input wire logic gprWe,
	input wire logic gprWide,
	input wire logic [2:0] gprWrIdx,
	input wire logic [15:0] gprWrData,
	input wire logic [7:0] memRdata,
	input wire logic [7:0] progRdata,
	output logic busy,
	output logic [15:0] fetchPtr,
	output logic [7:0] flagWord,
	output logic irqAccept,
	output logic [7:0] aluResult,
	output logic [7:0] gprRdByte,
	output logic [15:0] gprRdPair,
	output logic [15:0] memAddr,
	output logic [7:0] memWdata,
	output logic memWe,
	output logic memRe,
	output logic [15:0] progAddr,
	output logic progRe
);
	//--------------------------------------------------------------------
	// state and decode
	//--------------------------------------------------------------------
	cpu_regs_pkg::state_t state_r;
	cpu_regs_pkg::op_t kind_r;
	logic [1:0] byteCnt_r;
	logic [15:0] pc_r;
	logic [15:0] sp_r;
	logic [15:0] retAddr_r;
	logic [15:0] target_r;
	logic [15:0] vecAddr_r;
	logic [7:0] flag_r;
	logic [7:0] savedFlag_r;
	logic [7:0] popLo_r;
	logic [7:0] popHi_r;
	logic [7:0] vecLo_r;
	logic [7:0] gpr_r [0:31];
	logic take;
	logic [1:0] bankN;
	logic apbSetup;
	logic apbWr;
	logic [1:0] seqLen;
	logic seqLast;
	logic [7:0] pushByte;
	logic [15:0] pairVal;
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic cin;
	logic stackBad;
	logic [31:0] rdMux;
	logic mapped;

	// a command is taken only while no stack or vector sequence runs
	assign take = cmdValid && (state_r == cpu_regs_pkg::ST_IDLE);
	assign bankN = ~{flag_r[cpu_regs_pkg::FLG_BANKH], flag_r[cpu_regs_pkg::FLG_BANKL]};
	assign apbSetup = psel && !penable;
	assign apbWr = psel && penable && pready && pwrite;
	assign pairVal = {gpr_r[{bankN, cmdPair, 1'b1}], gpr_r[{bankN, cmdPair, 1'b0}]};
	assign cin = aluUseCarry && flag_r[cpu_regs_pkg::FLG_CARRY];
	assign stackBad = (sp_r < cpu_regs_pkg::STACK_LO) || (sp_r > cpu_regs_pkg::STACK_HI);
	assign fetchPtr = pc_r;
	assign flagWord = flag_r;

	// adder with nibble carry for the half carry flag
	always_comb begin
		if (aluSub) begin
			sum9 = {1'b0, aluA} - {1'b0, aluB} - {8'h00, cin};
			nib5 = {1'b0, aluA[3:0]} - {1'b0, aluB[3:0]} - {4'h0, cin};
		end else begin
			sum9 = {1'b0, aluA} + {1'b0, aluB} + {8'h00, cin};
			nib5 = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]} + {4'h0, cin};
		end
	end

	// byte count and push byte of the running sequence
	always_comb begin
		unique case (kind_r)
			cpu_regs_pkg::OP_ENTRY, cpu_regs_pkg::OP_IRQ_RETURN_OP: seqLen = cpu_regs_pkg::LEN_ENTRY;
			cpu_regs_pkg::OP_CALL, cpu_regs_pkg::OP_RET: seqLen = cpu_regs_pkg::LEN_CALL;
			default: seqLen = cpu_regs_pkg::LEN_FLAG;
		endcase
		seqLast = (byteCnt_r == seqLen - 2'h1);
		pushByte = savedFlag_r;
		if (kind_r == cpu_regs_pkg::OP_ENTRY) begin
			if (byteCnt_r == 2'h1) begin
				pushByte = retAddr_r[15:8];
			end else if (byteCnt_r == 2'h2) begin
				pushByte = retAddr_r[7:0];
			end
		end else if (kind_r == cpu_regs_pkg::OP_CALL) begin
			pushByte = (byteCnt_r == 2'h0) ? retAddr_r[15:8] : retAddr_r[7:0];
		end
	end

	//--------------------------------------------------------------------
	// sequencer
	//--------------------------------------------------------------------
	// reset starts a vector fetch from the bottom of program memory
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= cpu_regs_pkg::ST_VEC_RD;
			busy <= 1'b1;
			kind_r <= cpu_regs_pkg::OP_SEQ;
			byteCnt_r <= 2'h0;
			retAddr_r <= 16'h0000;
			target_r <= 16'h0000;
			vecAddr_r <= cpu_regs_pkg::RESET_VECTOR;
			savedFlag_r <= cpu_regs_pkg::FLAG_RESET;
		end else begin
			unique case (state_r)
				cpu_regs_pkg::ST_IDLE: begin
					if (take) begin
						kind_r <= cmdOp;
						byteCnt_r <= 2'h0;
						retAddr_r <= pc_r + {13'h0000, cmdLen};
						target_r <= cmdFromPair ? pairVal : cmdTarget;
						vecAddr_r <= {cmdVector[15:1], 1'b0};
						savedFlag_r <= flag_r;
						if (cmdOp == cpu_regs_pkg::OP_CALL || cmdOp == cpu_regs_pkg::OP_ENTRY ||
							cmdOp == cpu_regs_pkg::OP_PUSHF) begin
							state_r <= cpu_regs_pkg::ST_PUSH;
							busy <= 1'b1;
						end else if (cmdOp == cpu_regs_pkg::OP_RET ||
							cmdOp == cpu_regs_pkg::OP_IRQ_RETURN_OP || cmdOp == cpu_regs_pkg::OP_POPF) begin
							state_r <= cpu_regs_pkg::ST_POP_RD;
							busy <= 1'b1;
						end
					end
				end
				cpu_regs_pkg::ST_PUSH: begin
					if (seqLast) begin
						byteCnt_r <= 2'h0;
						busy <= (kind_r == cpu_regs_pkg::OP_ENTRY);
						state_r <= (kind_r == cpu_regs_pkg::OP_ENTRY) ?
							cpu_regs_pkg::ST_VEC_RD : cpu_regs_pkg::ST_IDLE;
					end else begin
						byteCnt_r <= byteCnt_r + 2'h1;
					end
				end
				cpu_regs_pkg::ST_POP_RD: begin
					state_r <= cpu_regs_pkg::ST_POP_WT;
				end
				cpu_regs_pkg::ST_POP_WT: begin
					if (seqLast) begin
						byteCnt_r <= 2'h0;
						busy <= 1'b0;
						state_r <= cpu_regs_pkg::ST_IDLE;
					end else begin
						byteCnt_r <= byteCnt_r + 2'h1;
						state_r <= cpu_regs_pkg::ST_POP_RD;
					end
				end
				cpu_regs_pkg::ST_VEC_RD: begin
					state_r <= cpu_regs_pkg::ST_VEC_WT;
				end
				cpu_regs_pkg::ST_VEC_WT: begin
					if (byteCnt_r == 2'h1) begin
						byteCnt_r <= 2'h0;
						busy <= 1'b0;
						state_r <= cpu_regs_pkg::ST_IDLE;
					end else begin
						byteCnt_r <= 2'h1;
						state_r <= cpu_regs_pkg::ST_VEC_RD;
					end
				end
				default: begin
					state_r <= cpu_regs_pkg::ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	// popped and vector bytes; low byte first, even address first
	always_ff @(posedge core_clk) begin
		if (rst) begin
			popLo_r <= 8'h00;
			popHi_r <= 8'h00;
			vecLo_r <= 8'h00;
		end else begin
			if (state_r == cpu_regs_pkg::ST_POP_WT && byteCnt_r == 2'h0) begin
				popLo_r <= memRdata;
			end
			if (state_r == cpu_regs_pkg::ST_POP_WT && byteCnt_r == 2'h1) begin
				popHi_r <= memRdata;
			end
			if (state_r == cpu_regs_pkg::ST_VEC_WT && byteCnt_r == 2'h0) begin
				vecLo_r <= progRdata;
			end
		end
	end

	//--------------------------------------------------------------------
	// fetch pointer
	//--------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pc_r <= cpu_regs_pkg::RESET_VECTOR;
		end else if (state_r == cpu_regs_pkg::ST_VEC_WT && byteCnt_r == 2'h1) begin
			pc_r <= {progRdata, vecLo_r};
		end else if (state_r == cpu_regs_pkg::ST_POP_WT && seqLast &&
			kind_r == cpu_regs_pkg::OP_RET) begin
			pc_r <= {memRdata, popLo_r};
		end else if (state_r == cpu_regs_pkg::ST_POP_WT && seqLast &&
			kind_r == cpu_regs_pkg::OP_IRQ_RETURN_OP) begin
			pc_r <= {popHi_r, popLo_r};
		end else if (state_r == cpu_regs_pkg::ST_PUSH && seqLast &&
			kind_r == cpu_regs_pkg::OP_CALL) begin
			pc_r <= target_r;
		end else if (take && cmdOp == cpu_regs_pkg::OP_SEQ) begin
			pc_r <= pc_r + {13'h0000, cmdLen};
		end else if (take && cmdOp == cpu_regs_pkg::OP_BRANCH) begin
			pc_r <= cmdFromPair ? pairVal : cmdTarget;
		end else if (apbWr && paddr == cpu_regs_pkg::OFS_FETCH) begin
			pc_r <= pwdata[15:0];
		end
	end

	//--------------------------------------------------------------------
	// flag word
	//--------------------------------------------------------------------
	// hardware updates win over a bus write in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			flag_r <= cpu_regs_pkg::FLAG_RESET;
		end else if (state_r == cpu_regs_pkg::ST_POP_WT && seqLast &&
			(kind_r == cpu_regs_pkg::OP_POPF || kind_r == cpu_regs_pkg::OP_IRQ_RETURN_OP)) begin
			flag_r <= memRdata & cpu_regs_pkg::FLAG_USED;
		end else if (take) begin
			unique case (cmdOp)
				cpu_regs_pkg::OP_MASK, cpu_regs_pkg::OP_ENTRY:
					flag_r[cpu_regs_pkg::FLG_GATE] <= 1'b0;
				cpu_regs_pkg::OP_UNMASK: flag_r[cpu_regs_pkg::FLG_GATE] <= 1'b1;
				cpu_regs_pkg::OP_BANK: begin
					flag_r[cpu_regs_pkg::FLG_BANKH] <= cmdBank[1];
					flag_r[cpu_regs_pkg::FLG_BANKL] <= cmdBank[0];
				end
				cpu_regs_pkg::OP_ALU: begin
					flag_r[cpu_regs_pkg::FLG_NULL] <= (sum9[7:0] == 8'h00);
					flag_r[cpu_regs_pkg::FLG_HALF] <= nib5[4];
					flag_r[cpu_regs_pkg::FLG_CARRY] <= sum9[8];
				end
				cpu_regs_pkg::OP_CARRY: flag_r[cpu_regs_pkg::FLG_CARRY] <= cmdBit;
				default: flag_r <= flag_r;
			endcase
		end else if (apbWr && paddr == cpu_regs_pkg::OFS_FLAG) begin
			flag_r <= pwdata[7:0] & cpu_regs_pkg::FLAG_USED;
		end
	end

	// alu result register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			aluResult <= 8'h00;
		end else if (take && cmdOp == cpu_regs_pkg::OP_ALU) begin
			aluResult <= sum9[7:0];
		end
	end

	// maskable request acceptance
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irqAccept <= 1'b0;
		end else begin
			irqAccept <= irqReq && flag_r[cpu_regs_pkg::FLG_GATE] && !irqMasked &&
				(!irqLowPrio || flag_r[cpu_regs_pkg::FLG_LEVEL]);
		end
	end

	//--------------------------------------------------------------------
	// stack top, memory and program ports
	//--------------------------------------------------------------------
	// stack top is deliberately not reset
	always_ff @(posedge core_clk) begin
		if (take && cmdOp == cpu_regs_pkg::OP_LDSP) begin
			sp_r <= cmdTarget;
		end else if (state_r == cpu_regs_pkg::ST_PUSH) begin
			sp_r <= sp_r - 16'h0001;
		end else if (state_r == cpu_regs_pkg::ST_POP_RD) begin
			sp_r <= sp_r + 16'h0001;
		end else if (apbWr && paddr == cpu_regs_pkg::OFS_STACK) begin
			sp_r <= pwdata[15:0];
		end
	end

	// data memory strobes: write below old top, read at old top
	always_ff @(posedge core_clk) begin
		if (rst) begin
			memAddr <= 16'h0000;
			memWdata <= 8'h00;
			memWe <= 1'b0;
			memRe <= 1'b0;
		end else begin
			memWe <= (state_r == cpu_regs_pkg::ST_PUSH);
			memRe <= (state_r == cpu_regs_pkg::ST_POP_RD);
			if (state_r == cpu_regs_pkg::ST_PUSH) begin
				memAddr <= sp_r - 16'h0001;
				memWdata <= pushByte;
			end else if (state_r == cpu_regs_pkg::ST_POP_RD) begin
				memAddr <= sp_r;
			end
		end
	end

	// program memory read for vectors
	always_ff @(posedge core_clk) begin
		if (rst) begin
			progAddr <= 16'h0000;
			progRe <= 1'b0;
		end else begin
			progRe <= (state_r == cpu_regs_pkg::ST_VEC_RD);
			if (state_r == cpu_regs_pkg::ST_VEC_RD) begin
				progAddr <= vecAddr_r | {15'h0000, byteCnt_r[0]};
			end
		end
	end

	//--------------------------------------------------------------------
	// general registers
	//--------------------------------------------------------------------
	// array index is the offset from the bottom of the register area
	always_ff @(posedge core_clk) begin
		if (gprWe && gprWide) begin
			gpr_r[{bankN, gprWrIdx[1:0], 1'b0}] <= gprWrData[7:0];
			gpr_r[{bankN, gprWrIdx[1:0], 1'b1}] <= gprWrData[15:8];
		end else if (gprWe) begin
			gpr_r[{bankN, gprWrIdx}] <= gprWrData[7:0];
		end else if (apbWr && paddr[7] && paddr[1:0] == 2'h0) begin // misaligned writes refused
			gpr_r[paddr[6:2]] <= pwdata[7:0];
		end
	end

	// registered read ports of the selected bank
	always_ff @(posedge core_clk) begin
		if (rst) begin
			gprRdByte <= 8'h00;
			gprRdPair <= 16'h0000;
		end else begin
			gprRdByte <= gpr_r[{bankN, gprRdIdx}];
			gprRdPair <= {gpr_r[{bankN, gprRdIdx[1:0], 1'b1}], gpr_r[{bankN, gprRdIdx[1:0], 1'b0}]};
		end
	end

	//--------------------------------------------------------------------
	// bus slave
	//--------------------------------------------------------------------
	always_comb begin
		mapped = (paddr[1:0] == 2'h0) && (paddr[7] || paddr <= cpu_regs_pkg::OFS_STATUS);
		rdMux = 32'h0000_0000;
		if (paddr[7]) begin
			rdMux = {24'h000000, gpr_r[paddr[6:2]]};
		end else if (paddr == cpu_regs_pkg::OFS_FETCH) begin
			rdMux = {16'h0000, pc_r};
		end else if (paddr == cpu_regs_pkg::OFS_FLAG) begin
			rdMux = {24'h000000, flag_r};
		end else if (paddr == cpu_regs_pkg::OFS_STACK) begin
			rdMux = {16'h0000, sp_r};
		end else if (paddr == cpu_regs_pkg::OFS_STATUS) begin
			rdMux = {22'h000000, ~bankN, 5'h00, stackBad, 1'b0, busy};
		end
	end

	// no wait states: answer registered during the setup cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= apbSetup;
			pslverr <= apbSetup && !mapped;
			if (apbSetup) begin
				prdata <= (mapped && !pwrite) ? rdMux : 32'h0000_0000;
			end
		end
	end

	//--------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence entryTaken;
		take && cmdOp == cpu_regs_pkg::OP_ENTRY;
	endsequence
	sequence entryPushes;
		(state_r == cpu_regs_pkg::ST_PUSH) [*3];
	endsequence

	seqAdvance_a: assert property (take && cmdOp == cpu_regs_pkg::OP_SEQ |=>
		pc_r == $past(pc_r) + {13'h0000, $past(cmdLen)}) else $error("fetch pointer step wrong");
	branchLoad_a: assert property (take && cmdOp == cpu_regs_pkg::OP_BRANCH && !cmdFromPair |=>
		pc_r == $past(cmdTarget)) else $error("branch target not loaded");
	vectorLoad_a: assert property (state_r == cpu_regs_pkg::ST_VEC_WT && byteCnt_r == 2'h1 |=>
		pc_r == {$past(progRdata), $past(vecLo_r)}) else $error("vector not assembled");
	resetFlag_a: assert property ($fell(rst) |-> flag_r == cpu_regs_pkg::FLAG_RESET)
		else $error("flag word reset value wrong");
	gateRefuse_a: assert property (!flag_r[cpu_regs_pkg::FLG_GATE] |=> !irqAccept)
		else $error("request accepted with gate closed");
	levelRefuse_a: assert property (irqLowPrio && !flag_r[cpu_regs_pkg::FLG_LEVEL] |=> !irqAccept)
		else $error("low priority accepted at level 0");
	maskClear_a: assert property (take && cmdOp == cpu_regs_pkg::OP_MASK |=>
		!flag_r[cpu_regs_pkg::FLG_GATE] ##1 !irqAccept)
		else $error("mask-all did not close gate");
	nullFlag_a: assert property (take && cmdOp == cpu_regs_pkg::OP_ALU |=>
		flag_r[cpu_regs_pkg::FLG_NULL] == (aluResult == 8'h00)) else $error("null flag wrong");
	pushAddr_a: assert property (memWe |-> memAddr == sp_r && $past(state_r) == cpu_regs_pkg::ST_PUSH)
		else $error("push not predecremented");
	popStep_a: assert property (state_r == cpu_regs_pkg::ST_POP_RD |=>
		memRe && sp_r == memAddr + 16'h0001) else $error("pop not postincremented");
	entryFlow_a: assert property (entryTaken |=> entryPushes ##1
		state_r == cpu_regs_pkg::ST_VEC_RD) else $error("entry did not push three bytes");
	entryFirst_a: assert property (entryTaken ##1 1'b1 |=> memWdata == $past(savedFlag_r, 1))
		else $error("flag word not pushed first");
endmodule : cpu_regs

// >>> mem_partner.sv
// data and program memory model facing the register block
`timescale 1ns/1ps
module mem_partner (
	input wire logic core_clk,
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memWdata,
	input wire logic memWe,
	input wire logic memRe,
	output logic [7:0] memRdata,
	input wire logic [15:0] progAddr,
	input wire logic progRe,
	output logic [7:0] progRdata
);
	logic [7:0] dmem [0:65535];
	logic [7:0] pmem [0:255];
	logic [7:0] lastD_r = 8'h00;
	logic [7:0] lastP_r = 8'h00;
	// byte stores from the stack sequencer, and last bus values
	always_ff @(posedge core_clk) begin
		if (memWe) begin
			dmem[memAddr] <= memWdata;
		end
		lastD_r <= memRdata;
		lastP_r <= progRdata;
	end
	// data only while strobed, a toggling value otherwise
	assign memRdata = memRe ? dmem[memAddr] : ~lastD_r;
	assign progRdata = progRe ? pmem[progAddr[7:0]] : ~lastP_r;
endmodule : mem_partner

// >>> tb.sv
// self-checking bench for the control and general register block
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'b0, rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic cmdValid = 1'b0, cmdFromPair = 1'b0, aluSub = 1'b0, aluUseCarry = 1'b0, cmdBit = 1'b0;
	cpu_regs_pkg::op_t cmdOp = cpu_regs_pkg::OP_NOP1;
	logic [2:0] cmdLen = 3'h0, gprRdIdx = 3'h0, gprWrIdx = 3'h0;
	logic [15:0] cmdTarget = 16'h0, cmdVector = 16'h0, gprWrData = 16'h0;
	logic [1:0] cmdPair = 2'h0, cmdBank = 2'h0;
	logic [7:0] aluA = 8'h00, aluB = 8'h00, memRdata, progRdata, memWdata, aluResult;
	logic irqReq = 1'b0, irqLowPrio = 1'b0, irqMasked = 1'b0, gprWe = 1'b0, gprWide = 1'b0;
	logic busy, irqAccept, memWe, memRe, progRe;
	logic [7:0] flagWord, gprRdByte;
	logic [15:0] fetchPtr, gprRdPair, memAddr, progAddr;
	int mismatches = 0, checks_done = 0;
	cpu_regs dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdLen(cmdLen),
		.cmdTarget(cmdTarget), .cmdFromPair(cmdFromPair), .cmdPair(cmdPair), .cmdBank(cmdBank),
		.cmdVector(cmdVector), .aluA(aluA), .aluB(aluB), .aluSub(aluSub),
		.aluUseCarry(aluUseCarry), .cmdBit(cmdBit), .irqReq(irqReq), .irqLowPrio(irqLowPrio),
		.irqMasked(irqMasked), .gprRdIdx(gprRdIdx), .gprWe(gprWe), .gprWide(gprWide),
		.gprWrIdx(gprWrIdx), .gprWrData(gprWrData), .memRdata(memRdata),
		.progRdata(progRdata), .busy(busy), .fetchPtr(fetchPtr), .flagWord(flagWord),
		.irqAccept(irqAccept), .aluResult(aluResult), .gprRdByte(gprRdByte),
		.gprRdPair(gprRdPair), .memAddr(memAddr), .memWdata(memWdata), .memWe(memWe),
		.memRe(memRe), .progAddr(progAddr), .progRe(progRe));
	mem_partner part (.core_clk(core_clk), .memAddr(memAddr), .memWdata(memWdata),
		.memWe(memWe), .memRe(memRe), .memRdata(memRdata), .progAddr(progAddr),
		.progRe(progRe), .progRdata(progRdata));
	// 200 MHz clock and watchdog
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
	//------------------------------------------------------------------------
	// shared tasks
	//------------------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// apb transfer held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) mismatches++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, d, x, e);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic e;
		apb(1'b0, a, 32'h0, rdv, e);
	endtask : rd
	// one command, then wait for busy low
	task automatic issue(input cpu_regs_pkg::op_t op);
		int n;
		n = 0;
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmdOp <= op;
		@(posedge core_clk);
		cmdValid <= 1'b0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (busy !== 1'b0 && n < 40);
		if (n == 40) mismatches++;
		// let the last stack store land in the partner
		@(posedge core_clk);
		#1;
	endtask : issue
	task automatic irq(input logic low, input logic msk, input logic exp);
		@(posedge core_clk);
		irqReq <= 1'b1;
		irqLowPrio <= low;
		irqMasked <= msk;
		repeat (2) @(posedge core_clk);
		#1;
		chk("irqAccept", 32'(irqAccept), 32'(exp));
	endtask : irq
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	//------------------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------------------
	task automatic t_apb();
		logic [31:0] x;
		logic e;
		logic [15:0] sps [4] = '{16'hfb00, 16'hfeff, 16'hfaff, 16'hff00};
		foreach (sps[i]) begin
			wr(cpu_regs_pkg::OFS_STACK, {16'h0, sps[i]});
			rd(cpu_regs_pkg::OFS_STATUS);
			chk("stack outside", rdv[2], 32'(i >= 2));
		end
		wr(cpu_regs_pkg::OFS_STACK, 32'h0000fe20);
		rd(cpu_regs_pkg::OFS_STACK);
		chk("stack top", rdv, 32'h0000fe20);
		apb(1'b0, 8'h10, 32'h0, x, e);
		chk("unmapped err", 32'(e), 32'h1);
		chk("unmapped data", x, 32'h0);
		$display("apb test done");
	endtask : t_apb
	task automatic t_flow();
		logic [31:0] x;
		logic e;
		issue(cpu_regs_pkg::OP_SEQ);
		chk("pc seq", fetchPtr, 32'h1237);
		cmdTarget <= 16'h0400;
		issue(cpu_regs_pkg::OP_BRANCH);
		chk("pc imm", fetchPtr, 32'h0400);
		@(posedge core_clk);
		gprWe <= 1'b1;
		gprWide <= 1'b1;
		gprWrIdx <= 3'h1;
		gprWrData <= 16'h4321;
		gprRdIdx <= 3'h1;
		@(posedge core_clk);
		gprWe <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		chk("pair read", gprRdPair, 32'h4321);
		rd(8'he8);
		chk("pair low byte", rdv, 32'h21);
		rd(8'hec);
		chk("pair high byte", rdv, 32'h43);
		apb(1'b1, 8'hed, 32'h0000_0055, x, e);
		chk("misaligned err", 32'(e), 32'h1);
		rd(8'hec);
		chk("misaligned ignored", rdv, 32'h43);
		@(posedge core_clk);
		gprWe <= 1'b1;
		gprWide <= 1'b0;
		gprWrIdx <= 3'h5;
		gprWrData <= 16'h0099;
		gprRdIdx <= 3'h5;
		@(posedge core_clk);
		gprWe <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		chk("byte read", gprRdByte, 32'h99);
		cmdFromPair <= 1'b1;
		cmdPair <= 2'h1;
		issue(cpu_regs_pkg::OP_BRANCH);
		chk("pc pair", fetchPtr, 32'h4321);
		cmdFromPair <= 1'b0;
		$display("flow test done");
	endtask : t_flow
	task automatic t_alu();
		logic [24:0] tv [4] = '{{8'h0f, 8'h01, 1'b0, 8'h10}, {8'hff, 8'h01, 1'b0, 8'h00},
			{8'h10, 8'h01, 1'b1, 8'h0f}, {8'h00, 8'h01, 1'b1, 8'hff}};
		logic [7:0] fl [4] = '{8'h10, 8'h51, 8'h10, 8'h11};
		foreach (tv[i]) begin
			aluA <= tv[i][24:17];
			aluB <= tv[i][16:9];
			aluSub <= tv[i][8];
			issue(cpu_regs_pkg::OP_ALU);
			chk("alu result", aluResult, tv[i][7:0]);
			chk("alu flags", flagWord & 8'h51, fl[i]);
		end
		cmdBit <= 1'b1;
		issue(cpu_regs_pkg::OP_CARRY);
		chk("carry set", flagWord[0], 32'h1);
		aluA <= 8'h0e;
		aluB <= 8'h01;
		aluSub <= 1'b0;
		aluUseCarry <= 1'b1;
		issue(cpu_regs_pkg::OP_ALU);
		chk("alu carry in", aluResult, 32'h10);
		chk("alu carry flags", flagWord & 8'h51, 32'h10);
		aluUseCarry <= 1'b0;
		$display("alu test done");
	endtask : t_alu
	task automatic t_irq();
		issue(cpu_regs_pkg::OP_MASK);
		irq(1'b0, 1'b0, 1'b0);
		issue(cpu_regs_pkg::OP_UNMASK);
		irq(1'b0, 1'b0, 1'b1);
		irq(1'b0, 1'b1, 1'b0);
		irq(1'b1, 1'b0, 1'b1);
		wr(cpu_regs_pkg::OFS_FLAG, 32'h84);
		rd(cpu_regs_pkg::OFS_FLAG);
		chk("flag bit2", rdv, 32'h80);
		irq(1'b1, 1'b0, 1'b0);
		irqReq <= 1'b0;
		cmdBank <= 2'h2;
		issue(cpu_regs_pkg::OP_BANK);
		chk("bank bits", flagWord & 8'h28, 32'h20);
		rd(cpu_regs_pkg::OFS_STATUS);
		chk("status bank", rdv[9:8], 32'h2);
		$display("irq test done");
	endtask : t_irq
	task automatic t_stack();
		cmdTarget <= 16'hfe20;
		issue(cpu_regs_pkg::OP_LDSP);
		cmdTarget <= 16'h2000;
		cmdLen <= 3'h3;
		issue(cpu_regs_pkg::OP_CALL);
		chk("call hi", part.dmem[16'hfe1f], 32'h43);
		chk("call lo", part.dmem[16'hfe1e], 32'h24);
		chk("call pc", fetchPtr, 32'h2000);
		issue(cpu_regs_pkg::OP_RET);
		chk("ret pc", fetchPtr, 32'h4324);
		wr(cpu_regs_pkg::OFS_FLAG, 32'h82);
		issue(cpu_regs_pkg::OP_PUSHF);
		chk("pushed flag", part.dmem[16'hfe1f], 32'h82);
		wr(cpu_regs_pkg::OFS_FLAG, 32'h02);
		issue(cpu_regs_pkg::OP_POPF);
		chk("popped flag", flagWord, 32'h82);
		cmdLen <= 3'h0;
		cmdVector <= 16'h0010;
		issue(cpu_regs_pkg::OP_ENTRY);
		chk("entry flag", part.dmem[16'hfe1f], 32'h82);
		chk("entry hi", part.dmem[16'hfe1e], 32'h43);
		chk("entry lo", part.dmem[16'hfe1d], 32'h24);
		chk("entry pc", fetchPtr, 32'h5678);
		chk("entry gate", flagWord, 32'h02);
		issue(cpu_regs_pkg::OP_IRQ_RETURN_OP);
		chk("irq_return_op pc", fetchPtr, 32'h4324);
		chk("irq_return_op flag", flagWord, 32'h82);
		rd(cpu_regs_pkg::OFS_STACK);
		chk("stack back", rdv, 32'h0000fe20);
		$display("stack test done");
	endtask : t_stack
	//------------------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------------------
	initial begin
		part.pmem[0] = 8'h34;
		part.pmem[1] = 8'h12;
		part.pmem[16] = 8'h78;
		part.pmem[17] = 8'h56;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (12) @(posedge core_clk);
		#1;
		chk("reset pc", fetchPtr, 32'h1234);
		chk("reset flag", flagWord, 32'(cpu_regs_pkg::FLAG_RESET));
		cmdLen <= 3'h3;
		t_apb();
		t_flow();
		t_alu();
		t_irq();
		t_stack();
		tally_and_finish();
	end
endmodule : tb
